// ==== design/fbo_params.svh ====
// Constants for the fieldbus option configuration and status block
`ifndef FBO_PARAMS_SVH
`define FBO_PARAMS_SVH
// Register byte offsets
`define FBO_REG_CFG      12'h000
`define FBO_REG_STAT     12'h004
`define FBO_REG_COMM     12'h008
`define FBO_REG_DIO      12'h00c
`define FBO_REG_ASSIGN   12'h010
`define FBO_REG_DIN      12'h014
`define FBO_REG_IRQ      12'h018
`define FBO_REG_MASK     12'h01c
`define FBO_REG_SIZE     12'h020
// Configuration fields: node[6:0] legacy[8] fmt[10:9] order[12:11] slots-1[14:13]
`define FBO_NODE_LSB     0
`define FBO_NODE_MAX     7'h63
`define FBO_NODE_RST     7'h63
`define FBO_LEGACY_BIT   8
`define FBO_FMT_LSB      9
`define FBO_ORD_LSB      11
`define FBO_SLOT_LSB     13
`define FBO_SLOT_RST     2'h0
// Status fields: mode[1:0], then one bit each
`define FBO_ST_MODE_LSB  0
`define FBO_ST_MAJ       2
`define FBO_ST_MIN       3
`define FBO_ST_SELF      4
`define FBO_ST_NODE      5
`define FBO_ST_NET       6
`define FBO_ST_TEMP      7
`define FBO_ST_OWN       8
// Interrupt bits
`define FBO_IRQ_SLOTCLR  0
`define FBO_IRQ_FAILOVER 1
`define FBO_IRQ_OWNED    2
`define FBO_IRQ_FAULT    3
// Words per slot, plus fixed reserved input words
`define FBO_INT_IN_WORDS  5'h02
`define FBO_INT_OUT_WORDS 5'h02
`define FBO_FLT_IN_WORDS  5'h04
`define FBO_FLT_OUT_WORDS 5'h03
`define FBO_RSV_IN_WORDS  5'h02
// Flash divider: half period of about 0.5 s at 200 MHz
`define FBO_CLK_HZ       200000000
`define FBO_FLASH_HALF_S_MS 500
`endif

// ==== design/fbo_pkg.sv ====
// Types for the fieldbus option configuration and status block
package fbo_pkg;
  typedef enum logic [1:0] {
    FBO_FMT_INT = 2'b00, FBO_FMT_DIV = 2'b01, FBO_FMT_FLT = 2'b10
  } fbo_fmt_t;
  typedef enum logic [1:0] {
    FBO_ORD_STD = 2'b00, FBO_ORD_BYTE = 2'b01, FBO_ORD_WORD = 2'b10, FBO_ORD_DWORD = 2'b11
  } fbo_ord_t;
  // LED pattern code; fbo_rg maps it to bit1 red, bit0 green
  typedef enum logic [2:0] {
    FBO_LED_OFF = 3'b000, FBO_LED_GRN = 3'b001, FBO_LED_GRN_FL = 3'b010,
    FBO_LED_RED = 3'b011, FBO_LED_RED_FL = 3'b100, FBO_LED_ALT = 3'b101,
    FBO_LED_RG_FL = 3'b110
  } fbo_led_t;
  typedef enum logic [1:0] {
    FBO_MOD_UNINIT = 2'b00, FBO_MOD_CONN = 2'b01, FBO_MOD_RUN = 2'b10
  } fbo_mod_t;
endpackage

// ==== design/fbo_led_if.sv ====
// Interface carrying LED patterns to the LED driver
`timescale 1ns/1ps
interface fbo_led_if;
  fbo_pkg::fbo_led_t mod_pat;
  fbo_pkg::fbo_led_t cha_pat;
  fbo_pkg::fbo_led_t chb_pat;
  logic              owned;
  logic              tick;
  logic [7:0]        drive;
  modport src (output mod_pat, cha_pat, chb_pat, owned, input tick, drive);
  modport drv (input mod_pat, cha_pat, chb_pat, owned, output tick, drive);
endinterface

// ==== design/fbo_led_drv.sv ====
// LED pattern driver with common flash divider
`timescale 1ns/1ps
`include "fbo_params.svh"
module fbo_led_drv #(
  parameter int HALF_CYCLES = (`FBO_CLK_HZ / 1000) * `FBO_FLASH_HALF_S_MS
) (
  input wire logic clk,
  input wire logic sys_rst,
  fbo_led_if.drv   led
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        phase;
    logic [7:0]  drive;
  } fbo_drv_st_t;
  fbo_drv_st_t st;
  fbo_drv_st_t next_st;

  // Pattern to red/green pair
  function automatic logic [1:0] fbo_rg(input fbo_pkg::fbo_led_t p, input logic ph);
    case (p)
      fbo_pkg::FBO_LED_GRN:    fbo_rg = 2'b01;
      fbo_pkg::FBO_LED_GRN_FL: fbo_rg = {1'b0, ph};
      fbo_pkg::FBO_LED_RED:    fbo_rg = 2'b10;
      fbo_pkg::FBO_LED_RED_FL: fbo_rg = {ph, 1'b0};
      fbo_pkg::FBO_LED_ALT:    fbo_rg = {ph, ~ph};
      fbo_pkg::FBO_LED_RG_FL:  fbo_rg = {ph, ph};
      default:                 fbo_rg = 2'b00;
    endcase
  endfunction

  // Free-running divider shared by all flashing LEDs
  always_comb begin
    next_st = st;
    if (st.cnt >= HALF_CYCLES - 1) begin // [RQ16]
      next_st.cnt   = 32'h0;
      next_st.phase = ~st.phase;
    end else begin
      next_st.cnt = st.cnt + 32'h1;
    end
    next_st.drive = {fbo_rg(led.mod_pat, st.phase), fbo_rg(led.cha_pat, st.phase),
                     fbo_rg(led.chb_pat, st.phase), 1'b0, led.owned}; // [RQ10] [RQ14]
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign led.drive = st.drive;
  assign led.tick  = (st.cnt == 32'h0);

  chk_flash_toggle: assert property (@(posedge clk) disable iff (sys_rst) // [RQ16]
    (st.cnt == HALF_CYCLES - 1) |=> (st.phase != $past(st.phase)))
    else $error("flash phase did not toggle");
endmodule

// ==== design/fbo_dio_gate.sv ====
// Discrete I/O sampling and output ownership gate
`timescale 1ns/1ps
module fbo_dio_gate #(
  parameter int N = 8
) (
  input wire logic         clk,
  input wire logic         sys_rst,
  input wire logic         upd,
  input wire logic [N-1:0] din_pin,
  input wire logic [N-1:0] plc_out,
  input wire logic [N-1:0] local_out,
  input wire logic [N-1:0] assigned,
  output logic     [N-1:0] din_img,
  output logic     [N-1:0] dout_pin
);
  typedef struct packed {
    logic [N-1:0] din;
    logic [N-1:0] dout;
  } fbo_dio_st_t;
  fbo_dio_st_t st;
  fbo_dio_st_t next_st;

  // Update only at the interface update instants
  always_comb begin
    next_st = st;
    if (upd) begin // [RQ1]
      next_st.din  = din_pin;
      next_st.dout = (assigned & local_out) | (~assigned & plc_out); // [RQ2]
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign din_img  = st.din;
  assign dout_pin = st.dout;

  chk_dout_hold: assert property (@(posedge clk) disable iff (sys_rst) // [RQ1]
    !upd |=> $stable(st.dout))
    else $error("output changed outside update");
  chk_local_own: assert property (@(posedge clk) disable iff (sys_rst) // [RQ2]
    upd |=> ((st.dout & $past(assigned)) == ($past(local_out) & $past(assigned))))
    else $error("assigned output taken by controller");
endmodule

// ==== design/fbo_top.sv ====
// Fieldbus option configuration, discrete I/O gating and status LEDs
`timescale 1ns/1ps
`include "fbo_params.svh"
// Notes on behaviour
// RQ1 - Discrete inputs and outputs update only at local interface update instants
// RQ2 - Controller drives an output only when no local function is assigned
// RQ3 - Channel A is normal; channel B used when A has no signal
// RQ4 - Node address 0 to 99, default 99
// RQ5 - Normal or legacy byte arrangement mode for discrete data
// RQ6 - Integer, divisions or float format; format change clears message slots
// RQ7 - Byte order standard, byte, word or double-word swap; word swap default
// RQ8 - One to four slots set cyclic input and output image size
// RQ9 - Board presence caught at startup enables fieldbus configuration
// RQ10 - Four LEDs: module, channel A, channel B, ownership
// RQ11 - Module LED: run green, connecting flash green, faults red, uninit off
// RQ12 - Both channel LEDs: major red, self test alternating, node error flash
// RQ13 - Channel LED: normal green, temporary flash green, media flash red
// RQ14 - Ownership LED off until a connection is opened, then green
// RQ15 - Per slot two in and two out words; float four in three out
// RQ16 - All flashing driven from one free-running divider of about one hertz
module fbo_top #(
  parameter int DIO_N       = 8,
  parameter int FLASH_HALF  = (`FBO_CLK_HZ / 1000) * `FBO_FLASH_HALF_S_MS
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             board_present,
  input  wire logic             upd_tick,
  input  wire logic             sig_a,
  input  wire logic             sig_b,
  input  wire logic [DIO_N-1:0] din_pin,
  input  wire logic [DIO_N-1:0] plc_out,
  input  wire logic [DIO_N-1:0] local_out,
  output logic      [DIO_N-1:0] dout_pin,
  output logic      [DIO_N-1:0] din_to_plc,
  output logic                  use_chan_b,
  output logic      [7:0]       led,
  output logic                  irq
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             init;
    logic             present;
    logic [6:0]       node;
    logic             legacy;
    fbo_pkg::fbo_fmt_t fmt;
    fbo_pkg::fbo_ord_t ord;
    logic [1:0]       slots;
    logic             slots_valid;
    fbo_pkg::fbo_mod_t mstate;
    logic             maj_fault;
    logic             min_fault;
    logic             self_test;
    logic             node_err;
    logic             net_err;
    logic             temp_err;
    logic             owned;
    logic [DIO_N-1:0] assign_map;
    logic [DIO_N-1:0] plc_dout;
    logic [3:0]       irq_stat;
    logic [3:0]       irq_mask;
    logic             irq;
    logic             use_b;
  } fbo_st_t;
  fbo_st_t st;
  fbo_st_t next_st;

  fbo_led_if led_bus ();
  logic [DIO_N-1:0] din_img;

  // Image size in words for the chosen format and slot count
  function automatic logic [4:0] fbo_in_words(input fbo_pkg::fbo_fmt_t f, input logic [1:0] s);
    logic [4:0] per;
    per = (f == fbo_pkg::FBO_FMT_FLT) ? `FBO_FLT_IN_WORDS : `FBO_INT_IN_WORDS;
    fbo_in_words = 5'(`FBO_RSV_IN_WORDS + per * ({3'h0, s} + 5'h01)); // [RQ15]
  endfunction
  function automatic logic [4:0] fbo_out_words(input fbo_pkg::fbo_fmt_t f, input logic [1:0] s);
    logic [4:0] per;
    per = (f == fbo_pkg::FBO_FMT_FLT) ? `FBO_FLT_OUT_WORDS : `FBO_INT_OUT_WORDS;
    fbo_out_words = 5'(per * ({3'h0, s} + 5'h01)); // [RQ8] [RQ15]
    if (f == fbo_pkg::FBO_FMT_FLT) begin
      fbo_out_words = 5'(fbo_out_words + 5'h01); // Leading reserved word
    end
  endfunction

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic wr;
    logic rd;
    logic [31:0] rv;
    logic [3:0]  ev;
    fbo_pkg::fbo_fmt_t nf;
    wr = 1'b0;
    rd = 1'b0;
    rv = 32'h0;
    ev = 4'h0;
    nf = st.fmt;
    next_st = st;
    next_st.pready  = 1'b0;
    next_st.pslverr = 1'b0;

    // Catch board presence once after reset release
    if (!st.init) begin // [RQ9]
      next_st.init    = 1'b1;
      next_st.present = board_present;
    end

    // APB access: answer one cycle after access phase begins
    if (psel && penable && !st.pready) begin
      wr = pwrite;
      rd = !pwrite;
      next_st.pready = 1'b1;
    end

    // Register read mux
    case (paddr)
      `FBO_REG_CFG:    rv = {17'h0, st.slots, st.ord, st.fmt, st.legacy, 1'b0, st.node};
      `FBO_REG_STAT:   rv = {21'h0, st.slots_valid, st.use_b, st.owned, st.temp_err,
                             st.net_err, st.node_err, st.self_test, st.min_fault,
                             st.maj_fault, st.mstate};
      `FBO_REG_COMM:   rv = {31'h0, st.present};
      `FBO_REG_DIO:    rv = 32'(st.plc_dout);
      `FBO_REG_ASSIGN: rv = 32'(st.assign_map);
      `FBO_REG_DIN:    rv = 32'(din_img);
      `FBO_REG_IRQ:    rv = {28'h0, st.irq_stat};
      `FBO_REG_MASK:   rv = {28'h0, st.irq_mask};
      `FBO_REG_SIZE:   rv = {19'h0, fbo_out_words(st.fmt, st.slots), 3'h0,
                             fbo_in_words(st.fmt, st.slots)};
      default: begin
        rv = 32'h0;
        if (psel && penable && !st.pready) begin
          next_st.pslverr = 1'b1;
        end
      end
    endcase
    if (rd) begin
      next_st.prdata = rv;
    end

    // Register writes; fieldbus setup only when the board is present
    if (wr) begin
      case (paddr)
        `FBO_REG_CFG: begin
          if (st.present) begin // [RQ9]
            if (pwdata[`FBO_NODE_LSB +: 7] <= `FBO_NODE_MAX) begin // [RQ4]
              next_st.node = pwdata[`FBO_NODE_LSB +: 7];
            end
            next_st.legacy = pwdata[`FBO_LEGACY_BIT]; // [RQ5]
            next_st.ord = fbo_pkg::fbo_ord_t'(pwdata[`FBO_ORD_LSB +: 2]); // [RQ7]
            nf = fbo_pkg::fbo_fmt_t'(pwdata[`FBO_FMT_LSB +: 2]);
            if (nf != fbo_pkg::FBO_FMT_INT && nf != fbo_pkg::FBO_FMT_DIV &&
                nf != fbo_pkg::FBO_FMT_FLT) begin
              nf = st.fmt;
            end
            next_st.fmt = nf;
            if (nf != st.fmt) begin // [RQ6]
              next_st.slots       = `FBO_SLOT_RST;
              next_st.slots_valid = 1'b0;
              ev[`FBO_IRQ_SLOTCLR] = 1'b1;
            end else begin
              next_st.slots       = pwdata[`FBO_SLOT_LSB +: 2]; // [RQ8]
              next_st.slots_valid = 1'b1;
            end
          end else begin
            next_st.pslverr = 1'b1;
          end
        end
        `FBO_REG_STAT: begin
          next_st.mstate    = fbo_pkg::fbo_mod_t'(pwdata[`FBO_ST_MODE_LSB +: 2]);
          next_st.maj_fault = pwdata[`FBO_ST_MAJ];
          next_st.min_fault = pwdata[`FBO_ST_MIN];
          next_st.self_test = pwdata[`FBO_ST_SELF];
          next_st.node_err  = pwdata[`FBO_ST_NODE];
          next_st.net_err   = pwdata[`FBO_ST_NET];
          next_st.temp_err  = pwdata[`FBO_ST_TEMP];
          next_st.owned     = pwdata[`FBO_ST_OWN];
          if (pwdata[`FBO_ST_OWN] && !st.owned) begin
            ev[`FBO_IRQ_OWNED] = 1'b1;
          end
          if (pwdata[`FBO_ST_MAJ] && !st.maj_fault) begin
            ev[`FBO_IRQ_FAULT] = 1'b1;
          end
        end
        `FBO_REG_DIO:    next_st.plc_dout   = pwdata[DIO_N-1:0];
        `FBO_REG_ASSIGN: next_st.assign_map = pwdata[DIO_N-1:0];
        `FBO_REG_MASK:   next_st.irq_mask   = pwdata[3:0];
        default: begin
        end
      endcase
    end

    // Channel selection: A normal, B when A has no signal and B has one
    next_st.use_b = !sig_a && sig_b; // [RQ3]
    if (next_st.use_b && !st.use_b) begin
      ev[`FBO_IRQ_FAILOVER] = 1'b1;
    end

    // Sticky status: write one clears, new event wins
    if (wr && paddr == `FBO_REG_IRQ) begin
      next_st.irq_stat = st.irq_stat & ~pwdata[3:0];
    end
    next_st.irq_stat = next_st.irq_stat | ev;
    next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st        <= '0;
      st.node   <= `FBO_NODE_RST; // [RQ4]
      st.ord    <= fbo_pkg::FBO_ORD_WORD; // [RQ7]
      st.fmt    <= fbo_pkg::FBO_FMT_INT; // [RQ6]
      st.slots  <= `FBO_SLOT_RST;
      st.slots_valid <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // LED pattern selection
  // ---------------------------------------------------------------
  always_comb begin
    if (st.maj_fault) begin // [RQ11]
      led_bus.mod_pat = fbo_pkg::FBO_LED_RED;
    end else if (st.min_fault) begin
      led_bus.mod_pat = fbo_pkg::FBO_LED_RED_FL;
    end else if (st.mstate == fbo_pkg::FBO_MOD_RUN) begin
      led_bus.mod_pat = fbo_pkg::FBO_LED_GRN;
    end else if (st.mstate == fbo_pkg::FBO_MOD_CONN) begin
      led_bus.mod_pat = fbo_pkg::FBO_LED_GRN_FL;
    end else begin
      led_bus.mod_pat = fbo_pkg::FBO_LED_OFF;
    end
    // Shared channel patterns take priority over per-channel ones
    if (!st.present) begin // [RQ12]
      led_bus.cha_pat = fbo_pkg::FBO_LED_OFF;
    end else if (st.maj_fault) begin
      led_bus.cha_pat = fbo_pkg::FBO_LED_RED;
    end else if (st.self_test) begin
      led_bus.cha_pat = fbo_pkg::FBO_LED_ALT;
    end else if (st.node_err) begin
      led_bus.cha_pat = fbo_pkg::FBO_LED_RED_FL;
    end else if (st.net_err) begin // [RQ13]
      led_bus.cha_pat = fbo_pkg::FBO_LED_RG_FL;
    end else if (st.temp_err) begin
      led_bus.cha_pat = fbo_pkg::FBO_LED_GRN_FL;
    end else begin
      led_bus.cha_pat = fbo_pkg::FBO_LED_GRN;
    end
    led_bus.chb_pat = led_bus.cha_pat;
    // Media fault per channel
    if (led_bus.cha_pat == fbo_pkg::FBO_LED_GRN && !sig_a) begin // [RQ13]
      led_bus.cha_pat = fbo_pkg::FBO_LED_RED_FL;
    end
    if (led_bus.chb_pat == fbo_pkg::FBO_LED_GRN && !sig_b) begin
      led_bus.chb_pat = fbo_pkg::FBO_LED_RED_FL;
    end
    led_bus.owned = st.owned; // [RQ14]
  end

  fbo_led_drv #(.HALF_CYCLES(FLASH_HALF)) u_led (
    .clk     (clk),
    .sys_rst (sys_rst),
    .led     (led_bus)
  );

  fbo_dio_gate #(.N(DIO_N)) u_dio (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .upd       (upd_tick),
    .din_pin   (din_pin),
    .plc_out   (plc_out | st.plc_dout),
    .local_out (local_out),
    .assigned  (st.assign_map),
    .din_img   (din_img),
    .dout_pin  (dout_pin)
  );

  assign prdata     = st.prdata;
  assign pready     = st.pready;
  assign pslverr    = st.pslverr;
  assign irq        = st.irq;
  assign use_chan_b = st.use_b;
  assign led        = led_bus.drive;
  assign din_to_plc = din_img;

  chk_chan_select: assert property (@(posedge clk) disable iff (sys_rst) // [RQ3]
    sig_a |=> !use_chan_b)
    else $error("backup channel used while primary has signal");
  chk_node_range: assert property (@(posedge clk) disable iff (sys_rst) // [RQ4]
    st.node <= `FBO_NODE_MAX)
    else $error("node address out of range");
  chk_fmt_clear: assert property (@(posedge clk) disable iff (sys_rst) // [RQ6]
    (st.fmt != $past(st.fmt)) |-> (!st.slots_valid && st.irq_stat[`FBO_IRQ_SLOTCLR]))
    else $error("format change kept message slots");
  chk_absent_cfg: assert property (@(posedge clk) disable iff (sys_rst) // [RQ9]
    (st.init && !st.present) |=> $stable(st.node) && $stable(st.fmt))
    else $error("configuration changed without board");
  chk_own_led: assert property (@(posedge clk) disable iff (sys_rst) // [RQ14]
    !st.owned [*2] |=> !led[0])
    else $error("ownership led lit without connection");
  chk_mod_off: assert property (@(posedge clk) disable iff (sys_rst) // [RQ11]
    (st.mstate == fbo_pkg::FBO_MOD_UNINIT && !st.maj_fault && !st.min_fault) [*2]
      |=> led[7:6] == 2'b00)
    else $error("module led lit while not initialized");
  chk_size_int: assert property (@(posedge clk) disable iff (sys_rst) // [RQ8]
    (st.fmt == fbo_pkg::FBO_FMT_INT && st.slots == 2'h3) |->
      fbo_in_words(st.fmt, st.slots) == 5'h0a)
    else $error("input image size wrong");
  chk_mod_red: assert property (@(posedge clk) disable iff (sys_rst) // [RQ11]
    st.maj_fault [*2] |=> led[7:6] == 2'b10)
    else $error("module led not red on major fault");
endmodule

// ==== testbench/fbo_plc_model.sv ====
// Controller model standing on the far side of the redundant fieldbus
`timescale 1ns/1ps
module fbo_plc_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] cmd,
  input  wire logic [1:0] chan,
  input  wire logic [7:0] din_to_plc,
  output logic      [7:0] plc_out,
  output logic            sig_a,
  output logic            sig_b,
  output logic      [7:0] seen
);
  // ----------------------------------------
  // Scan image and channel carriers
  // ----------------------------------------
  // Controller scans on its own clock edge, unrelated to the terminal update instants
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      plc_out <= 8'h00;
      sig_a   <= 1'b0;
      sig_b   <= 1'b0;
      seen    <= 8'h00;
    end else begin
      plc_out <= cmd;
      sig_a   <= chan[0];  // Carrier present on the normal coax
      sig_b   <= chan[1];  // Carrier present on the redundant coax
      seen    <= din_to_plc;
    end
  end
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the fieldbus option configuration and status block
`timescale 1ns/1ps
`include "fbo_params.svh"
module tb_top;
  logic        clk;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        board_present;
  logic        upd_tick;
  logic        sig_a;
  logic        sig_b;
  logic [7:0]  din_pin;
  logic [7:0]  plc_out;
  logic [7:0]  local_out;
  logic [7:0]  dout_pin;
  logic [7:0]  din_to_plc;
  logic        use_chan_b;
  logic [7:0]  led;
  logic        irq;
  logic [7:0]  cmd;
  logic [1:0]  chan;
  logic [7:0]  seen;
  logic [31:0] rdat;
  logic        perr;
  int          fail_count;
  int          total_checks;

  // ----------------------------------------
  // Instances
  // ----------------------------------------
  fbo_top #(.DIO_N(8), .FLASH_HALF(8)) u_fbo_top (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .board_present(board_present), .upd_tick(upd_tick), .sig_a(sig_a), .sig_b(sig_b),
    .din_pin(din_pin), .plc_out(plc_out), .local_out(local_out), .dout_pin(dout_pin),
    .din_to_plc(din_to_plc), .use_chan_b(use_chan_b), .led(led), .irq(irq));
  fbo_plc_model u_fbo_plc_model (
    .clk(clk), .sys_rst(sys_rst), .cmd(cmd), .chan(chan), .din_to_plc(din_to_plc),
    .plc_out(plc_out), .sig_a(sig_a), .sig_b(sig_b), .seen(seen));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  // One APB transfer, entered just after a rising edge; idle cycle afterwards
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    perr = pslverr;
    if (n >= 20) chk("pready wait", 0, 1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, rdat, e);
  endtask

  task automatic rst_pulse();
    sys_rst <= 1'b1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // Counts changes of one LED bit over forty cycles
  task automatic flash(input int b, output int n);
    logic p;
    n = 0;
    p = led[b];
    repeat (40) begin
      @(posedge clk);
      if (led[b] !== p) n++;
      p = led[b];
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_defaults();
    rdc("cfg default", `FBO_REG_CFG, 32'h0000_1063);
    rdc("size default", `FBO_REG_SIZE, 32'h0000_0204);
    rdc("presence", `FBO_REG_COMM, 32'h0000_0001);
  endtask

  task automatic t_cfg();
    logic [31:0] v;
    for (int o = 0; o < 4; o++) begin
      v = 32'(o) << 11;
      apb(1'b1, `FBO_REG_CFG, v);
      rdc("order", `FBO_REG_CFG, v);
    end
    apb(1'b1, `FBO_REG_CFG, 32'h0000_1163);
    apb(1'b1, `FBO_REG_CFG, 32'h0000_1164);
    rdc("node above max", `FBO_REG_CFG, 32'h0000_1163);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, `FBO_REG_CFG, 32'h0000_1063 | (32'(s) << 13));
      rdc("int size", `FBO_REG_SIZE, (32'(2 * s + 2) << 8) | 32'(2 * s + 4));
    end
    apb(1'b1, `FBO_REG_CFG, 32'h0000_7263);
    rdc("div clears slots", `FBO_REG_CFG, 32'h0000_1263);
    apb(1'b1, `FBO_REG_CFG, 32'h0000_7263);
    rdc("div size", `FBO_REG_SIZE, 32'h0000_080a);
    apb(1'b1, `FBO_REG_CFG, 32'h0000_7463);
    rdc("flt size one", `FBO_REG_SIZE, 32'h0000_0406);
    apb(1'b1, `FBO_REG_CFG, 32'h0000_7463);
    rdc("flt size four", `FBO_REG_SIZE, 32'h0000_0d12);
    apb(1'b1, `FBO_REG_CFG, 32'h0000_7663);
    rdc("bad format", `FBO_REG_CFG, 32'h0000_7463);
  endtask

  task automatic t_irq();
    rdc("irq status", `FBO_REG_IRQ, 32'h0000_0001);
    chk("irq masked", irq, 1'b0);
    apb(1'b1, `FBO_REG_MASK, 32'h0000_000f);
    chk("irq raised", irq, 1'b1);
    apb(1'b1, `FBO_REG_IRQ, 32'h0000_0001);
    chk("irq cleared", irq, 1'b0);
    apb(1'b0, 12'h024, 32'h0000_0000);
    chk("unmapped err", perr, 1'b1);
    chk("unmapped data", rdat, 32'h0000_0000);
  endtask

  task automatic t_dio();
    apb(1'b1, `FBO_REG_ASSIGN, 32'h0000_000f);
    local_out <= 8'haa;
    cmd <= 8'h55;
    din_pin <= 8'h3c;
    repeat (6) @(posedge clk);
    chk("dout before tick", dout_pin, 8'h00);
    chk("din before tick", din_to_plc, 8'h00);
    upd_tick <= 1'b1;
    @(posedge clk);
    upd_tick <= 1'b0;
    repeat (3) @(posedge clk);
    chk("dout gated", dout_pin, 8'h5a);
    chk("din image", seen, 8'h3c);
    apb(1'b1, `FBO_REG_DIO, 32'h0000_0081);
    chk("dout held", dout_pin, 8'h5a);
    upd_tick <= 1'b1;
    @(posedge clk);
    upd_tick <= 1'b0;
    repeat (3) @(posedge clk);
    chk("dout reg or", dout_pin, 8'hda);
  endtask

  task automatic t_chan();
    chk("chan a normal", use_chan_b, 1'b0);
    chan <= 2'b10;
    repeat (4) @(posedge clk);
    chk("chan b used", use_chan_b, 1'b1);
    rdc("failover", `FBO_REG_IRQ, 32'h0000_0002);
    chan <= 2'b11;
    repeat (4) @(posedge clk);
    chk("chan a back", use_chan_b, 1'b0);
    apb(1'b1, `FBO_REG_IRQ, 32'h0000_000f);
  endtask

  task automatic t_led();
    int n;
    apb(1'b1, `FBO_REG_STAT, 32'h0000_0002);
    chk("run leds", led, 8'h54);
    apb(1'b1, `FBO_REG_STAT, 32'h0000_0102);
    chk("owned", led, 8'h55);
    apb(1'b1, `FBO_REG_STAT, 32'h0000_0106);
    chk("major", led, 8'ha9);
    rdc("led events", `FBO_REG_IRQ, 32'h0000_000c);
    apb(1'b1, `FBO_REG_STAT, 32'h0000_0001);
    flash(6, n);
    chk("connect flash", 32'(n >= 4 && n <= 5), 1);
    chk("not owned", {led[7], led[0]}, 2'b00);
    apb(1'b1, `FBO_REG_STAT, 32'h0000_000a);
    flash(7, n);
    chk("minor flash", 32'(n >= 4 && n <= 5), 1);
    apb(1'b1, `FBO_REG_STAT, 32'h0000_0012);
    flash(5, n);
    chk("self test", 32'(n >= 4 && n <= 5), 1);
    chk("alternate", led[5] ^ led[4], 1'b1);
    apb(1'b1, `FBO_REG_STAT, 32'h0000_0022);
    flash(5, n);
    chk("node err", {30'(n >= 4 && n <= 5), led[4], led[2]}, 32'h4);
    apb(1'b1, `FBO_REG_STAT, 32'h0000_0042);
    flash(4, n);
    chk("net err", {30'(n >= 4 && n <= 5), led[5] ^ led[4], led[3] ^ led[2]}, 32'h4);
    apb(1'b1, `FBO_REG_STAT, 32'h0000_0082);
    flash(4, n);
    chk("temp err", {31'(n >= 4 && n <= 5), led[5]}, 32'h2);
    apb(1'b1, `FBO_REG_STAT, 32'h0000_0002);
    chan <= 2'b10;
    repeat (3) @(posedge clk);
    flash(5, n);
    chk("media flash", 32'(n >= 4 && n <= 5), 1);
    chan <= 2'b11;
    apb(1'b1, `FBO_REG_STAT, 32'h0000_0000);
    chk("uninit", led[7:6], 2'b00);
  endtask

  task automatic t_noboard();
    board_present <= 1'b0;
    rst_pulse();
    rdc("no presence", `FBO_REG_COMM, 32'h0000_0000);
    apb(1'b1, `FBO_REG_CFG, 32'h0000_0000);
    chk("cfg refused", perr, 1'b1);
    rdc("cfg kept", `FBO_REG_CFG, 32'h0000_1063);
    chk("channels off", led[5:2], 4'h0);
  endtask

  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Whole run needs about 600 cycles; over thirty times that is a hang
  initial begin
    #100000;
    fail_count++;
    close_out();
  end

  initial begin
    fail_count = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    board_present = 1'b1;
    upd_tick = 1'b0;
    din_pin = 8'h00;
    local_out = 8'h00;
    cmd = 8'h00;
    chan = 2'b11;
    @(posedge clk);
    rst_pulse();
    t_defaults();
    t_cfg();
    t_irq();
    t_dio();
    t_chan();
    t_led();
    t_noboard();
    close_out();
  end
endmodule
